// *** palette_map.vh ***
/*
 palette port constants: i/o addresses, register widths, palette geometry and host spacing.
 assumes a 16-bit i/o address and byte-wide host data.
*/
`ifndef PALETTE_MAP_VH
`define PALETTE_MAP_VH

// accelerator-native register window
`define ADDR_NATIVE_MASK 16'h02ea
`define ADDR_NATIVE_RPTR 16'h02eb
`define ADDR_NATIVE_WPTR 16'h02ec
`define ADDR_NATIVE_DATA 16'h02ed
// vga-compatible window, same register order
`define ADDR_VGA_MASK 16'h03c6
`define ADDR_VGA_DATA 16'h03c9

// register fields and reset values
`define REG_WIDTH 8
`define COMP_WIDTH 6
`define ENTRY_COUNT 256
`define INDEX_WIDTH 8
`define MASK_RESET 8'hff
`define PTR_RESET 8'h00

// byte position inside an entry
`define PHASE_RED 2'h0
`define PHASE_GREEN 2'h1
`define PHASE_BLUE 2'h2

// passthrough select encoding
`define PASSTHRU_VGA 1'b0
`define PASSTHRU_ACCEL 1'b1

// least host write spacing, ns, and clock period, ns
`define HOST_WRITE_GAP_NS 240
`define CLK_PERIOD_NS 8

`endif

// *** palette_ram.v ***
/*
 palette storage: one entry per index, three colour components packed in a word.
 assumes a single clock; read data is registered, one cycle after the request.
*/
`timescale 1ns/1ns
module palette_ram #(
    parameter DEPTH = 256,
    parameter AW = 8,
    parameter DW = 18
) (
    input wire clk,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [DW-1:0] rd_data
);

    reg [DW-1:0] mem [0:DEPTH-1];

    // no reset on storage, contents undefined until loaded
    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule

// *** palette_dac_host_port.v ***
/*
 host byte i/o port of the colour palette: mask, read pointer, write pointer, data.
 assumes the host strobes io_wr or io_rd for one cycle per access, synchronous to clk,
 and keeps its own spacing between palette accesses.
 a data read needs three quiet cycles after a pointer load or an entry change.
*/
// Functional notes
// - writes decode both native and vga windows
// - reads answer only at the native window
// - vga passthrough mirrors vga writes to palette
// - accelerator mode keeps vga accesses off palette
// - write pointer advances after third data write
// - read pointer advances after third data read
// - pointers keep advancing across successive entries
// - no ready flag is ever given
// - pixel mask gates the lookup index
// - pointers readable and writable, read current value
// - 256 entries of three six-bit components
// - passthrough zero vga, one accelerator
`timescale 1ns/1ns
`include "palette_map.vh"
module palette_dac_host_port #(
    parameter ENTRIES = `ENTRY_COUNT,
    parameter IW = `INDEX_WIDTH,
    parameter CW = `COMP_WIDTH
) (
    input wire clk,
    input wire arst_n,
    input wire [15:0] io_addr,
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_wdata,
    output reg [7:0] io_rdata,
    output reg io_rdata_valid,
    input wire vga_video_passthrough_select,
    input wire [IW-1:0] pixel_index,
    output reg [3*CW-1:0] pixel_rgb
);

    // register select codes, same order in both windows
    localparam [1:0] SEL_MASK = 2'h0;
    localparam [1:0] SEL_RPTR = 2'h1;
    localparam [1:0] SEL_WPTR = 2'h2;
    localparam [1:0] SEL_DATA = 2'h3;

    // host entry fetch states; nothing tells the host when a fetch is done
    localparam [1:0] FETCH_IDLE = 2'h0;
    localparam [1:0] FETCH_WAIT = 2'h1;
    localparam [1:0] FETCH_LAND = 2'h2;

    reg [7:0] pixel_lookup_mask_q;
    reg [IW-1:0] palette_read_pointer_q;
    reg [IW-1:0] palette_read_pointer_d;
    reg [IW-1:0] palette_write_pointer_q;
    reg [IW-1:0] palette_write_pointer_d;
    reg [1:0] wr_phase_q;
    reg [1:0] wr_phase_d;
    reg [1:0] rd_phase_q;
    reg [1:0] rd_phase_d;
    reg [CW-1:0] wr_red_q;
    reg [CW-1:0] wr_green_q;
    reg [3*CW-1:0] rd_entry_q;
    reg [1:0] fetch_state_q;
    reg [1:0] fetch_state_d;
    reg [CW-1:0] rd_comp;
    reg [7:0] io_rdata_d;

    wire [3*CW-1:0] ram_rd_data;
    wire [3*CW-1:0] ram_wr_data;
    wire ram_wr_en;
    wire [IW-1:0] ram_rd_addr;
    reg [IW-1:0] lookup_idx_q;
    reg lookup_turn_q;

    // window decode: offset within the four-register group
    wire in_native = (io_addr >= `ADDR_NATIVE_MASK) && (io_addr <= `ADDR_NATIVE_DATA);
    wire in_vga = (io_addr >= `ADDR_VGA_MASK) && (io_addr <= `ADDR_VGA_DATA);
    wire [15:0] native_off = io_addr - `ADDR_NATIVE_MASK;
    wire [15:0] vga_off = io_addr - `ADDR_VGA_MASK;
    wire vga_reaches = vga_video_passthrough_select == `PASSTHRU_VGA;
    // accelerator video keeps vga programming on its own dac
    wire vga_wr_ok = in_vga && vga_reaches;
    wire [1:0] sel = in_native ? native_off[1:0] : vga_off[1:0];
    wire wr_hit = io_wr && (in_native || vga_wr_ok);
    wire rd_hit = io_rd && in_native;

    wire wr_mask = wr_hit && (sel == SEL_MASK);
    wire wr_rptr = wr_hit && (sel == SEL_RPTR);
    wire wr_wptr = wr_hit && (sel == SEL_WPTR);
    wire wr_data = wr_hit && (sel == SEL_DATA);
    wire rd_data = rd_hit && (sel == SEL_DATA);
    // anything that moves the read pointer or rewrites an entry forces a refetch
    wire rd_advance = rd_data && (rd_phase_q == `PHASE_BLUE);
    wire entry_stale = wr_rptr || ram_wr_en || rd_advance;

    // blue write completes an entry
    assign ram_wr_en = wr_data && (wr_phase_q == `PHASE_BLUE);
    assign ram_wr_data = {wr_red_q, wr_green_q, io_wdata[CW-1:0]};
    // port alternates: lookup index on its turn, read pointer otherwise
    assign ram_rd_addr = lookup_turn_q ? lookup_idx_q : palette_read_pointer_q;

    palette_ram #(
        .DEPTH(ENTRIES),
        .AW(IW),
        .DW(3*CW)
    ) u_ram (
        .clk(clk),
        .wr_en(ram_wr_en),
        .wr_addr(palette_write_pointer_q),
        .wr_data(ram_wr_data),
        .rd_addr(ram_rd_addr),
        .rd_data(ram_rd_data)
    );

    // mask register, written from either window when allowed
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pixel_lookup_mask_q <= `MASK_RESET;
        end else if (wr_mask) begin
            pixel_lookup_mask_q <= io_wdata;
        end
    end

    // read pointer next value: a load, or a step after the blue byte
    always @* begin
        palette_read_pointer_d = palette_read_pointer_q;
        rd_phase_d = rd_phase_q;
        if (wr_rptr) begin
            palette_read_pointer_d = io_wdata[IW-1:0];
            rd_phase_d = `PHASE_RED;
        end else if (rd_data) begin
            if (rd_phase_q == `PHASE_BLUE) begin
                // binary increment wraps past the last entry
                palette_read_pointer_d = palette_read_pointer_q + {{(IW-1){1'b0}}, 1'b1};
                rd_phase_d = `PHASE_RED;
            end else begin
                rd_phase_d = rd_phase_q + 2'h1;
            end
        end
    end

    // write pointer next value: a load, or a step when blue commits
    always @* begin
        palette_write_pointer_d = palette_write_pointer_q;
        wr_phase_d = wr_phase_q;
        if (wr_wptr) begin
            palette_write_pointer_d = io_wdata[IW-1:0];
            wr_phase_d = `PHASE_RED;
        end else if (wr_data) begin
            case (wr_phase_q)
                `PHASE_RED: begin
                    wr_phase_d = `PHASE_GREEN;
                end
                `PHASE_GREEN: begin
                    wr_phase_d = `PHASE_BLUE;
                end
                default: begin
                    palette_write_pointer_d = palette_write_pointer_q + {{(IW-1){1'b0}}, 1'b1};
                    wr_phase_d = `PHASE_RED;
                end
            endcase
        end
    end

    // read side pointer and byte position
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            palette_read_pointer_q <= `PTR_RESET;
            rd_phase_q <= `PHASE_RED;
        end else begin
            palette_read_pointer_q <= palette_read_pointer_d;
            rd_phase_q <= rd_phase_d;
        end
    end

    // write side pointer and byte position
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            palette_write_pointer_q <= `PTR_RESET;
            wr_phase_q <= `PHASE_RED;
        end else begin
            palette_write_pointer_q <= palette_write_pointer_d;
            wr_phase_q <= wr_phase_d;
        end
    end

    // red and green wait here until blue completes the entry
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_red_q <= {CW{1'b0}};
            wr_green_q <= {CW{1'b0}};
        end else if (wr_data) begin
            if (wr_phase_q == `PHASE_RED) begin
                wr_red_q <= io_wdata[CW-1:0];
            end
            if (wr_phase_q == `PHASE_GREEN) begin
                wr_green_q <= io_wdata[CW-1:0];
            end
        end
    end

    // one read port, shared: lookup on odd turns, host fetch on even ones
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lookup_turn_q <= 1'b0;
        end else begin
            lookup_turn_q <= ~lookup_turn_q;
        end
    end

    // host fetch sequencer: a fetch only counts if nothing moved meanwhile
    always @* begin
        fetch_state_d = fetch_state_q;
        case (fetch_state_q)
            FETCH_IDLE: begin
                if (entry_stale) begin
                    fetch_state_d = FETCH_WAIT;
                end
            end
            FETCH_WAIT: begin
                if (!entry_stale && !lookup_turn_q) begin
                    fetch_state_d = FETCH_LAND;
                end
            end
            FETCH_LAND: begin
                if (entry_stale) begin
                    fetch_state_d = FETCH_WAIT;
                end else begin
                    fetch_state_d = FETCH_IDLE;
                end
            end
            default: begin
                fetch_state_d = FETCH_WAIT;
            end
        endcase
    end

    // entry capture; a data read inside the refetch window sees the old entry
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fetch_state_q <= FETCH_WAIT;
            rd_entry_q <= {3*CW{1'b0}};
        end else begin
            fetch_state_q <= fetch_state_d;
            if ((fetch_state_q == FETCH_LAND) && !entry_stale) begin
                rd_entry_q <= ram_rd_data;
            end
        end
    end

    // masked index, registered so the ram address is clean for its turn
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lookup_idx_q <= {IW{1'b0}};
        end else begin
            lookup_idx_q <= pixel_index & pixel_lookup_mask_q[IW-1:0];
        end
    end

    // lookup result lands the cycle after its turn on the port
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pixel_rgb <= {3*CW{1'b0}};
        end else if (!lookup_turn_q) begin
            pixel_rgb <= ram_rd_data;
        end
    end

    // colour component picked by the read phase
    always @* begin
        case (rd_phase_q)
            `PHASE_RED: rd_comp = rd_entry_q[3*CW-1:2*CW];
            `PHASE_GREEN: rd_comp = rd_entry_q[2*CW-1:CW];
            default: rd_comp = rd_entry_q[CW-1:0];
        endcase
    end

    // byte for a native read, top bits of a colour read as zero
    always @* begin
        case (sel)
            SEL_MASK: io_rdata_d = pixel_lookup_mask_q;
            SEL_RPTR: io_rdata_d = palette_read_pointer_q;
            SEL_WPTR: io_rdata_d = palette_write_pointer_q;
            default: io_rdata_d = {{(8-CW){1'b0}}, rd_comp};
        endcase
    end

    // read answer registered; valid is a one-cycle reply, not a ready flag
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            io_rdata <= 8'h00;
            io_rdata_valid <= 1'b0;
        end else begin
            io_rdata_valid <= rd_hit;
            if (rd_hit) begin
                io_rdata <= io_rdata_d;
            end
        end
    end

endmodule

// *** host_io_model.sv ***
/* host side model: paced byte reads and writes with one-cycle strobes.
   assumes the port answers a native read one cycle after its strobe. */
`timescale 1ns/1ns
`include "palette_map.vh"
module host_io_model (
    input wire clk,
    output reg [15:0] io_addr,
    output reg io_wr,
    output reg io_rd,
    output reg [7:0] io_wdata,
    input wire [7:0] io_rdata,
    input wire io_rdata_valid
);
    initial begin
        io_addr = 16'h0000;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end
    // drop the strobe, scramble released lines, keep 240 ns before the next access
    task finish_access;
        begin
            io_wr = 1'b0;
            io_rd = 1'b0;
            io_addr = ~io_addr;
            io_wdata = ~io_wdata;
            repeat (`HOST_WRITE_GAP_NS / `CLK_PERIOD_NS) @(posedge clk);
        end
    endtask
    // pointer loads and r,g,b bytes are issued in the order the caller gives
    task wr(input [15:0] a, input [7:0] d);
        begin
            @(posedge clk);
            #1;
            io_addr = a;
            io_wdata = d;
            io_wr = 1'b1;
            @(posedge clk);
            #1;
            finish_access;
        end
    endtask
    // answer is taken one edge after the strobe edge
    task rd(input [15:0] a, output [7:0] d, output v);
        begin
            @(posedge clk);
            #1;
            io_addr = a;
            io_rd = 1'b1;
            @(posedge clk);
            #1;
            io_rd = 1'b0;
            @(posedge clk);
            v = io_rdata_valid;
            d = io_rdata;
            #1;
            finish_access;
        end
    endtask
endmodule

// *** palette_dac_host_port_props.sv ***
/* checker: read answers, refusals, data width and mask readback.
   assumes the host keeps its access spacing. */
`timescale 1ns/1ns
module palette_dac_host_port_props #(
    parameter IW = 8,
    parameter CW = 6
) (
    input wire clk,
    input wire arst_n,
    input wire [15:0] io_addr,
    input wire io_wr,
    input wire io_rd,
    input wire [7:0] io_wdata,
    input wire [7:0] io_rdata,
    input wire io_rdata_valid,
    input wire vga_video_passthrough_select,
    input wire [IW-1:0] pixel_index,
    input wire [3*CW-1:0] pixel_rgb
);
    wire nat = io_addr >= 16'h02ea && io_addr <= 16'h02ed;
    wire vga = io_addr >= 16'h03c6 && io_addr <= 16'h03c9;
    wire mask_wr = io_addr == 16'h02ea || (io_addr == 16'h03c6 && !vga_video_passthrough_select);
    reg [7:0] mask_q;
    // shadow of the mask; vga window only counts in passthrough
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_q <= 8'hff;
        end else if (io_wr && mask_wr) begin
            mask_q <= io_wdata;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_rd_answer; io_rd && nat |=> io_rdata_valid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("native read unanswered");
    property p_vga_quiet; io_rd && vga |=> !io_rdata_valid; endproperty
    a_vga_quiet: assert property (p_vga_quiet) else $error("vga read answered");
    property p_wr_silent; io_wr |=> !io_rdata_valid; endproperty
    a_wr_silent: assert property (p_wr_silent) else $error("write answered");
    property p_cause; io_rdata_valid |-> $past(io_rd) && $past(nat); endproperty
    a_cause: assert property (p_cause) else $error("answer without native read");
    property p_pulse; io_rdata_valid && !io_rd |=> !io_rdata_valid; endproperty
    a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
    property p_hold; !io_rdata_valid |-> $stable(io_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_six; io_rdata_valid && $past(io_addr) == 16'h02ed |-> io_rdata[7:6] == 2'h0; endproperty
    a_six: assert property (p_six) else $error("colour byte wider than six bits");
    property p_mask; io_rdata_valid && $past(io_addr) == 16'h02ea |-> io_rdata == mask_q; endproperty
    a_mask: assert property (p_mask) else $error("mask readback wrong");
    c_vga_wr: cover property (io_wr && vga && !vga_video_passthrough_select);
    c_vga_rd: cover property (io_rd && vga);
    c_data_rd: cover property (io_rdata_valid && $past(io_addr) == 16'h02ed);
endmodule
bind palette_dac_host_port palette_dac_host_port_props #(.IW(IW), .CW(CW)) u_props (.clk(clk), .arst_n(arst_n),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_rdata_valid(io_rdata_valid), .vga_video_passthrough_select(vga_video_passthrough_select),
    .pixel_index(pixel_index), .pixel_rgb(pixel_rgb));

// *** palette_dac_host_port_tb_top.sv ***
/* bench: window decoding, pointer wrap, entry load and fetch, pixel lookup.
   assumes the host model paces every access. */
`timescale 1ns/1ns
`include "palette_map.vh"
module palette_dac_host_port_tb_top;
    reg clk = 1'b0;
    reg arst_n = 1'b0;
    reg sel = 1'b0;
    reg [7:0] pix = 8'h00;
    wire [15:0] io_addr;
    wire io_wr, io_rd, io_rdata_valid;
    wire [7:0] io_wdata, io_rdata;
    wire [17:0] rgb;
    reg [7:0] d;
    reg v;
    integer n_mismatch = 0;
    integer checked = 0;
    integer cyc = 0;
    integer i;
    always #4 clk = ~clk;
    palette_dac_host_port u_palette_dac_host_port (.clk(clk), .arst_n(arst_n), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
        .vga_video_passthrough_select(sel), .pixel_index(pix), .pixel_rgb(rgb));
    host_io_model u_host_io_model (.clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid));
    task chk(input string nm, input [17:0] seen, input [17:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // valid and data compared together
    task rdc(input string nm, input [15:0] a, input [7:0] exp);
        begin
            u_host_io_model.rd(a, d, v);
            chk(nm, {v, d}, {1'b1, exp});
        end
    endtask
    task tally_and_finish;
        begin
            if (n_mismatch == 0 && checked > 0) begin
                $display("[ PASS ]");
            end else begin
                $display("[ FAIL ]");
            end
            $finish;
        end
    endtask
    // ceiling well above the 34 paced accesses
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish;
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        #1;
        arst_n = 1'b1;
        @(posedge clk);
        rdc("mask reset", `ADDR_NATIVE_MASK, `MASK_RESET);
        u_host_io_model.wr(`ADDR_VGA_MASK, 8'ha5);
        rdc("mask via vga", `ADDR_NATIVE_MASK, 8'ha5);
        #1;
        sel = 1'b1;
        u_host_io_model.wr(`ADDR_VGA_MASK, 8'h3c);
        rdc("mask kept", `ADDR_NATIVE_MASK, 8'ha5);
        u_host_io_model.rd(`ADDR_VGA_MASK, d, v);
        chk("vga read valid", v, 1'b0);
        // entries ff and 00 across the wrap; top bits must drop
        u_host_io_model.wr(`ADDR_NATIVE_WPTR, 8'hff);
        rdc("wptr", `ADDR_NATIVE_WPTR, 8'hff);
        for (i = 1; i <= 6; i = i + 1) u_host_io_model.wr(`ADDR_NATIVE_DATA, 8'hc0 | i[7:0]);
        rdc("wptr wrap", `ADDR_NATIVE_WPTR, 8'h01);
        u_host_io_model.wr(`ADDR_NATIVE_RPTR, 8'hff);
        rdc("rptr", `ADDR_NATIVE_RPTR, 8'hff);
        rdc("red", `ADDR_NATIVE_DATA, 8'h01);
        u_host_io_model.wr(`ADDR_NATIVE_RPTR, 8'hff);
        for (i = 1; i <= 6; i = i + 1) rdc("entry byte", `ADDR_NATIVE_DATA, i[7:0]);
        rdc("rptr wrap", `ADDR_NATIVE_RPTR, 8'h01);
        // vga window loads an entry in passthrough
        #1;
        sel = 1'b0;
        u_host_io_model.wr(16'h03c8, 8'h10);
        for (i = 0; i < 3; i = i + 1) u_host_io_model.wr(`ADDR_VGA_DATA, 8'h07);
        rdc("wptr via vga", `ADDR_NATIVE_WPTR, 8'h11);
        #1;
        pix = 8'hff;
        u_host_io_model.wr(`ADDR_NATIVE_MASK, 8'hff);
        chk("pixel ff", rgb, {6'h01, 6'h02, 6'h03});
        u_host_io_model.wr(`ADDR_NATIVE_MASK, 8'h00);
        chk("pixel masked", rgb, {6'h04, 6'h05, 6'h06});
        u_host_io_model.wr(`ADDR_NATIVE_MASK, 8'h10);
        chk("pixel mask 10", rgb, {6'h07, 6'h07, 6'h07});
        tally_and_finish;
    end
endmodule
